// ---- design/pmoc_top.sv ----
// What this block does
// - Two-bit field picks scan interval during activation.
// - Late release: deassert below half touch threshold.
// - Proximity threshold exceeded freezes drift filters.
// - Proximity drives a pin only in prox-touch mode.
// - Percentage delta above touch threshold triggers activation.
// - Movement when delta exceeds movement threshold.
// - No-movement timeout clears activation in some modes.
// - Pulse-density mode: 10 ms pulses, 20 ms period at level 249, longer at lower levels.
// - Saturated movement holds pulse-density output low.
// - Mode 01 gives 1 kHz movement PWM.
// - Mode 10 latches output on first movement.
// - Latch releases after no-movement timer.
// - Mode 11 pulses only while activated.
// - Movement-input mode puts movement on primary pin.
// - AC filter increase bit strengthens sample filter.
// - In activation-and-movement mode, multifunction bit makes primary pin depth PWM.
// - Depth PWM forces movement mode 01 to 00.
// - Cleared multifunction bit: input means halt/reseed.
// - Set multifunction bit: input pulse toggles reduced sensitivity.
// - Low 15 to 25 ms requests reseed.
// - Low over 50 ms halts; release soft-resets.
// - Reduced sensitivity: filter doubles, proximity and touch thresholds raised.
`timescale 1ns/10ps
`default_nettype none
`include "pmoc_defs.svh"
module pmoc_top #(
  parameter int MS_CYCLES = `PMOC_MS_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic i_cfg_write,
  input wire logic [7:0] i_scan_time_config,
  input wire logic [7:0] i_threshold_config,
  input wire logic [7:0] i_timer_output_ui_config,
  input wire logic [7:0] i_filter_input_misc_config,
  input wire logic i_sample_valid,
  input wire logic [11:0] i_lta,
  input wire logic [11:0] i_lta_delta,
  input wire logic [11:0] i_move_delta,
  input wire logic i_primary_pin_in,
  input wire logic i_secondary_pin_in,
  output logic o_primary_pin_out,
  output logic o_primary_pin_oe,
  output logic o_secondary_pin_out,
  output logic o_secondary_pin_oe,
  output logic o_activation,
  output logic o_filter_freeze,
  output logic o_reseed,
  output logic o_halt_charge,
  output logic o_soft_reset,
  output logic o_reduced,
  output logic [2:0] o_ac_filter_shift,
  output logic [7:0] o_act_scan_ms,
  output logic [7:0] o_scan_time_config,
  output logic [7:0] o_threshold_config,
  output logic [7:0] o_timer_output_ui_config,
  output logic [7:0] o_filter_input_misc_config
);
  import pmoc_pkg::*;

  // ----------------------------------------------------------------
  // Tables and constants
  // ----------------------------------------------------------------
  localparam logic [3:0][7:0] SCAN_TBL = `PMOC_SCAN_TBL;
  localparam logic [3:0][11:0] PROX_TBL = `PMOC_PROX_TBL;
  localparam logic [7:0][6:0] TOUCH_TBL = `PMOC_TOUCH_TBL;
  localparam logic [3:0][11:0] MOV_TBL = `PMOC_MOV_TBL;
  localparam logic [7:0][8:0] TMR_TBL = `PMOC_TMR_TBL;
  localparam logic [11:0] SAT = 12'(`PMOC_PWM_STEPS);

  logic [1:0] rst_sync;
  logic rst_n;
  pmoc_state_t s;
  pmoc_state_t n;
  logic [2:0] ui;
  logic [1:0] mov_mode;
  logic depth_pwm;
  logic [11:0] prox_thr;
  logic [11:0] mov_thr;
  logic [11:0] excess;
  logic prox_hit;
  logic move_hit;
  logic [20:0] delta100;
  logic [20:0] on_lim;
  logic act_on;
  logic act_off;
  logic sec_wrap;
  logic timeout;
  logic in_pin;
  logic mov_level;

  pmoc_wave_if mov_w ();
  pmoc_wave_if dep_w ();

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // Decisions from the current sample
  // ----------------------------------------------------------------
  assign ui = s.tmr[2:0];
  assign depth_pwm = (ui == `PMOC_UI_ACT_MOV) && s.misc[`PMOC_MULTI_BIT];
  assign mov_mode = (depth_pwm && s.tmr[4:3] == `PMOC_MOV_PWM) ? `PMOC_MOV_PFM
                  : s.tmr[4:3];
  assign prox_thr = PROX_TBL[s.thr[6:5]] + (s.reduce ? `PMOC_RS_PROX_ADD : 12'h000);
  assign prox_hit = i_lta_delta > prox_thr;
  assign mov_thr = MOV_TBL[s.thr[1:0]];
  assign move_hit = i_move_delta > mov_thr;
  assign excess = i_move_delta - mov_thr;
  assign delta100 = 21'(i_lta_delta * `PMOC_PCT_SCALE);
  assign on_lim = 21'(i_lta * TOUCH_TBL[s.thr[4:2]])
                + (s.reduce ? `PMOC_RS_ACT_ADD100 : 21'h000000);
  assign act_on = delta100 > on_lim;
  // Late release compares twice the delta, which is half the threshold without a divider.
  assign act_off = s.thr[`PMOC_LATE_BIT] ? ({delta100[19:0], 1'b0} < on_lim)
                 : (delta100 <= on_lim);
  assign sec_wrap = s.ms_tick && (s.sec_ms == 10'(`PMOC_MS_PER_S - 1));
  assign timeout = sec_wrap && (s.idle_s + 9'h001 == TMR_TBL[s.tmr[7:5]]);
  assign in_pin = i_secondary_pin_in;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    n.reseed = 1'b0;
    n.soft_rst = 1'b0;
    n.ms_tick = 1'b0;
    if (s.ms_cnt == 17'(MS_CYCLES - 1)) begin
      n.ms_cnt = '0;
      n.ms_tick = 1'b1;
    end else begin
      n.ms_cnt = s.ms_cnt + 17'h00001;
    end

    if (!s.loaded || s.soft_rst || i_cfg_write) begin
      n.loaded = 1'b1;
      n.scan = i_scan_time_config;
      n.thr = i_threshold_config;
      n.tmr = i_timer_output_ui_config;
      n.misc = i_filter_input_misc_config;
    end

    if (s.ms_tick) begin
      n.sec_ms = sec_wrap ? 10'h000 : s.sec_ms + 10'h001;
      if (sec_wrap && s.idle_s != 9'h1FF) begin
        n.idle_s = s.idle_s + 9'h001;
      end
    end

    // Sensing stops entirely during halt charge.
    if (i_sample_valid && s.pin_st != PIN_HALT) begin
      n.prox = prox_hit;
      n.intens = move_hit ? ((excess > SAT) ? SAT[7:0] : excess[7:0]) : 8'h00;
      n.depth = (i_lta_delta > SAT) ? SAT[7:0] : i_lta_delta[7:0];
      if (move_hit) begin
        n.latch = 1'b1;
        n.idle_s = '0;
        n.sec_ms = '0;
      end
      if (!s.act && act_on && !s.forced_off) begin
        n.act = 1'b1;
      end else if (s.act && act_off) begin
        n.act = 1'b0;
      end
      if (act_off) begin
        n.forced_off = 1'b0;
      end
    end

    // A movement in the same sample restarts the timer, so it wins over the timeout.
    if (timeout && !(i_sample_valid && move_hit)) begin
      n.latch = 1'b0;
      if (ui == `PMOC_UI_ACT_MOV || ui == `PMOC_UI_PROX_TOUCH) begin
        n.act = 1'b0;
        n.forced_off = 1'b1;
        n.reseed = 1'b1;
      end
    end

    // Only the movement-and-input interface listens to the secondary pin.
    unique case (s.pin_st)
      PIN_IDLE: begin
        if (ui == `PMOC_UI_MOV_INPUT && !in_pin) begin
          n.pin_st = PIN_LOW;
          n.low_ms = '0;
        end
      end
      PIN_LOW: begin
        if (in_pin) begin
          n.pin_st = PIN_IDLE;
          if (s.low_ms >= 7'(`PMOC_RESEED_MIN_MS) && s.low_ms < 7'(`PMOC_RESEED_MAX_MS)) begin
            if (s.misc[`PMOC_MULTI_BIT]) begin
              n.reduce = ~s.reduce;
            end else begin
              n.reseed = 1'b1;
            end
          end
        end else if (s.ms_tick) begin
          // Saturating keeps a very long press from wrapping back into the reseed window.
          n.low_ms = (s.low_ms == 7'h7F) ? s.low_ms : s.low_ms + 7'h01;
          if (s.low_ms >= 7'(`PMOC_HALT_MS) && !s.misc[`PMOC_MULTI_BIT]) begin
            n.pin_st = PIN_HALT;
          end
        end
      end
      PIN_HALT: begin
        if (in_pin) begin
          n.pin_st = PIN_IDLE;
          n.soft_rst = 1'b1;
        end
      end
    endcase

    // Soft reset keeps the activation state but restarts timers and sensitivity.
    if (s.soft_rst) begin
      n.latch = 1'b0;
      n.reduce = 1'b0;
      n.forced_off = 1'b0;
      n.idle_s = '0;
      n.sec_ms = '0;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{scan: `PMOC_CFG_RESET, thr: `PMOC_CFG_RESET, tmr: `PMOC_CFG_RESET,
             misc: `PMOC_CFG_RESET, pin_st: PIN_IDLE, default: '0};
    end else if (i_clk_en) begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Waveform generators
  // ----------------------------------------------------------------
  assign mov_w.level = s.intens;
  assign mov_w.ms_tick = s.ms_tick;
  assign dep_w.level = s.depth;
  assign dep_w.ms_tick = s.ms_tick;

  pmoc_wave_gen #(.STEP_CYCLES(`PMOC_PWM_STEP_CYCLES)) u_mov (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_clk_en(i_clk_en),
    .w(mov_w.gen)
  );

  pmoc_wave_gen #(.STEP_CYCLES(`PMOC_PWM_STEP_CYCLES)) u_dep (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_clk_en(i_clk_en),
    .w(dep_w.gen)
  );

  // ----------------------------------------------------------------
  // Pin routing, all outputs active low
  // ----------------------------------------------------------------
  always_comb begin
    unique case (mov_mode)
      `PMOC_MOV_PFM: mov_level = mov_w.pfm_n;
      `PMOC_MOV_PWM: mov_level = ~mov_w.pwm;
      `PMOC_MOV_LATCH: mov_level = ~s.latch;
      `PMOC_MOV_PFM_ACT: mov_level = s.act ? mov_w.pfm_n : 1'b1;
    endcase
  end

  always_comb begin
    o_primary_pin_out = 1'b1;
    o_primary_pin_oe = 1'b1;
    o_secondary_pin_out = 1'b1;
    o_secondary_pin_oe = 1'b1;
    unique case (ui)
      `PMOC_UI_ACT_MOV: begin
        o_primary_pin_out = depth_pwm ? ~dep_w.pwm : ~s.act;
        o_secondary_pin_out = mov_level;
      end
      `PMOC_UI_LATCH_MOV: begin
        o_primary_pin_out = ~s.latch;
        o_secondary_pin_out = mov_level;
      end
      `PMOC_UI_MOV_INPUT: begin
        o_primary_pin_out = mov_level;
        o_secondary_pin_oe = 1'b0;
      end
      `PMOC_UI_PROX_TOUCH: begin
        o_primary_pin_out = ~s.prox;
        o_secondary_pin_out = ~s.act;
      end
      default: begin
        o_primary_pin_oe = 1'b0;
        o_secondary_pin_oe = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Status towards the measurement engine
  // ----------------------------------------------------------------
  assign o_activation = s.act;
  assign o_filter_freeze = s.prox;
  assign o_reseed = s.reseed;
  assign o_halt_charge = (s.pin_st == PIN_HALT);
  assign o_soft_reset = s.soft_rst;
  assign o_reduced = s.reduce;
  assign o_ac_filter_shift = `PMOC_AC_BASE_SHIFT + {2'h0, s.misc[`PMOC_ACF_BIT]}
                           + {2'h0, s.reduce};
  assign o_act_scan_ms = s.act ? SCAN_TBL[s.scan[1:0]] : 8'h00;
  assign o_scan_time_config = s.scan;
  assign o_threshold_config = s.thr;
  assign o_timer_output_ui_config = s.tmr;
  assign o_filter_input_misc_config = s.misc;
  // The primary pin input is not used by these interfaces.
  logic unused_in;
  assign unused_in = i_primary_pin_in;
endmodule : pmoc_top
`default_nettype wire

// ---- inc/pmoc_defs.svh ----
`ifndef PMOC_DEFS_SVH
`define PMOC_DEFS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define PMOC_CLK_PERIOD_NS 8
`define PMOC_MS_NS 1000000
`define PMOC_MS_CYCLES (`PMOC_MS_NS / `PMOC_CLK_PERIOD_NS)
`define PMOC_PWM_HZ 1000
`define PMOC_PWM_STEPS 250
`define PMOC_PWM_STEP_CYCLES (1000000000 / (`PMOC_PWM_HZ * `PMOC_CLK_PERIOD_NS * `PMOC_PWM_STEPS))
`define PMOC_PFM_PULSE_MS 10
`define PMOC_PFM_PERIOD_MS 20
`define PMOC_MS_PER_S 1000
`define PMOC_RESEED_MIN_MS 15
`define PMOC_RESEED_MAX_MS 25
`define PMOC_HALT_MS 50

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define PMOC_CFG_RESET 8'h00
`define PMOC_UI_ACT_MOV 3'h0
`define PMOC_UI_LATCH_MOV 3'h1
`define PMOC_UI_MOV_INPUT 3'h2
`define PMOC_UI_PROX_TOUCH 3'h3
`define PMOC_MOV_PFM 2'h0
`define PMOC_MOV_PWM 2'h1
`define PMOC_MOV_LATCH 2'h2
`define PMOC_MOV_PFM_ACT 2'h3
`define PMOC_LATE_BIT 7
`define PMOC_ACF_BIT 2
`define PMOC_MULTI_BIT 1

// ----------------------------------------------------------------
// Lookup tables, highest code first
// ----------------------------------------------------------------
`define PMOC_SCAN_TBL {8'h80, 8'h40, 8'h20, 8'h10}
`define PMOC_PROX_TBL {12'h010, 12'h008, 12'h004, 12'h002}
`define PMOC_TOUCH_TBL {7'h5A, 7'h3C, 7'h1E, 7'h0F, 7'h0A, 7'h06, 7'h04, 7'h02}
`define PMOC_MOV_TBL {12'h008, 12'h006, 12'h004, 12'h002}
`define PMOC_TMR_TBL {9'h1E0, 9'h0F0, 9'h078, 9'h03C, 9'h028, 9'h014, 9'h00A, 9'h005}
`define PMOC_RS_PROX_ADD 12'h004
`define PMOC_RS_ACT_ADD100 21'h003E8
`define PMOC_PCT_SCALE 12'h064
`define PMOC_AC_BASE_SHIFT 3'h2

`endif

// ---- inc/pmoc_pkg.sv ----
package pmoc_pkg;
  typedef enum logic [1:0] {PIN_IDLE, PIN_LOW, PIN_HALT} pmoc_pin_st_t;

  typedef struct packed {
    logic [7:0] scan;
    logic [7:0] thr;
    logic [7:0] tmr;
    logic [7:0] misc;
    logic loaded;
    logic act;
    logic prox;
    logic latch;
    logic forced_off;
    logic reseed;
    logic soft_rst;
    logic reduce;
    pmoc_pin_st_t pin_st;
    logic [16:0] ms_cnt;
    logic ms_tick;
    logic [9:0] sec_ms;
    logic [8:0] idle_s;
    logic [6:0] low_ms;
    logic [7:0] intens;
    logic [7:0] depth;
  } pmoc_state_t;

  typedef struct packed {
    logic [9:0] pre;
    logic [7:0] step;
    logic [8:0] pfm_ms;
    logic pfm_n;
    logic pwm;
  } pmoc_wave_t;
endpackage : pmoc_pkg

// ---- inc/pmoc_wave_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface pmoc_wave_if;
  logic [7:0] level;
  logic ms_tick;
  logic pfm_n;
  logic pwm;
  modport src (output level, output ms_tick, input pfm_n, input pwm);
  modport gen (input level, input ms_tick, output pfm_n, output pwm);
endinterface : pmoc_wave_if
`default_nettype wire

// ---- design/pmoc_wave_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pmoc_defs.svh"
module pmoc_wave_gen #(
  parameter int STEP_CYCLES = `PMOC_PWM_STEP_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  pmoc_wave_if.gen w
);
  import pmoc_pkg::*;
  localparam logic [7:0] FULL = 8'(`PMOC_PWM_STEPS);
  localparam logic [8:0] PERIOD_TOP = 9'(`PMOC_PWM_STEPS + `PMOC_PFM_PERIOD_MS - 1);
  pmoc_wave_t s;
  pmoc_wave_t n;
  logic [8:0] period;

  // ----------------------------------------------------------------
  // Pulse density: level 249 gives a 20 ms period, lower levels stretch it.
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    period = PERIOD_TOP - {1'b0, w.level};
    if (s.pre == 10'(STEP_CYCLES - 1)) begin
      n.pre = '0;
      n.step = (s.step == FULL - 8'h01) ? 8'h00 : s.step + 8'h01;
    end else begin
      n.pre = s.pre + 10'h001;
    end
    n.pwm = (s.step < w.level);
    if (w.ms_tick) begin
      if (w.level == 8'h00) begin
        n.pfm_ms = '0;
        n.pfm_n = 1'b1;
      end else if (w.level >= FULL) begin
        n.pfm_ms = '0;
        n.pfm_n = 1'b0;
      end else begin
        n.pfm_ms = (s.pfm_ms >= period - 9'h001) ? 9'h000 : s.pfm_ms + 9'h001;
        n.pfm_n = (n.pfm_ms >= 9'(`PMOC_PFM_PULSE_MS));
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '{pre: '0, step: '0, pfm_ms: '0, pfm_n: 1'b1, pwm: 1'b0};
    end else if (i_clk_en) begin
      s <= n;
    end
  end

  assign w.pfm_n = s.pfm_n;
  assign w.pwm = s.pwm;
endmodule : pmoc_wave_gen
`default_nettype wire

// ---- dv/pmoc_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module pmoc_host #(
  parameter int MS_CYCLES = 4
) (
  input wire logic i_clock,
  input wire logic i_start,
  input wire logic [7:0] i_low_ms,
  output logic o_pin
);
  // ----------------------------------------
  // Host driving the input pin
  // ----------------------------------------
  int left = 0;
  always @(posedge i_clock) begin
    if (i_start) begin
      left <= int'(i_low_ms) * MS_CYCLES;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end
  // The line has a pull-up, so a released pin reads high.
  assign o_pin = (left == 0);
endmodule : pmoc_host
`default_nettype wire

// ---- dv/pmoc_top_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module pmoc_top_sva #(
  parameter int MS_CYCLES = 4
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic i_sample_valid,
  input wire logic [11:0] i_lta,
  input wire logic [11:0] i_lta_delta,
  input wire logic o_primary_pin_out,
  input wire logic o_primary_pin_oe,
  input wire logic o_secondary_pin_out,
  input wire logic o_secondary_pin_oe,
  input wire logic o_activation,
  input wire logic o_filter_freeze,
  input wire logic o_reseed,
  input wire logic o_halt_charge,
  input wire logic o_soft_reset,
  input wire logic o_reduced,
  input wire logic [2:0] o_ac_filter_shift,
  input wire logic [7:0] o_act_scan_ms,
  input wire logic [7:0] o_scan_time_config,
  input wire logic [7:0] o_threshold_config,
  input wire logic [7:0] o_timer_output_ui_config,
  input wire logic [7:0] o_filter_input_misc_config
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  localparam logic [63:0] PCT = {8'h5A, 8'h3C, 8'h1E, 8'h0F, 8'h0A, 8'h06, 8'h04, 8'h02};
  logic [7:0] pct;
  logic [23:0] d100, lim;
  logic [11:0] prox;
  logic [2:0] ui;
  logic take, off_now, fr;
  assign pct = PCT[o_threshold_config[4:2]*8 +: 8];
  assign d100 = 24'(i_lta_delta) * 24'h64;
  assign lim = 24'(i_lta) * 24'(pct) + (o_reduced ? 24'h3E8 : 24'h0);
  assign prox = (12'h2 << o_threshold_config[6:5]) + (o_reduced ? 12'h4 : 12'h0);
  assign fr = i_lta_delta > prox;
  assign ui = o_timer_output_ui_config[2:0];
  assign take = i_sample_valid && i_clk_en && !o_halt_charge;
  assign off_now = o_threshold_config[7] ? ((d100 << 1) < lim) : (d100 <= lim);

  sequence s_gated_idle;
    (ui == 3'h0 && o_timer_output_ui_config[4:3] == 2'h3 && !o_activation)[*3];
  endsequence
  sequence s_halt_end;
    o_halt_charge ##1 !o_halt_charge;
  endsequence
  property p_scan;
    o_act_scan_ms == (o_activation ? 8'h10 << o_scan_time_config[1:0] : 8'h00);
  endproperty
  property p_shift;
    o_ac_filter_shift == 3'h2 + 3'(o_filter_input_misc_config[2]) + 3'(o_reduced);
  endproperty
  property p_freeze;
    take |=> o_filter_freeze == $past(fr);
  endproperty
  property p_act_off;
    take && off_now |=> !o_activation;
  endproperty
  property p_prox_ui;
    ui == 3'h3 |-> o_primary_pin_oe && o_primary_pin_out == !o_filter_freeze
      && o_secondary_pin_out == !o_activation;
  endproperty
  property p_input_ui;
    ui == 3'h2 |-> o_primary_pin_oe && !o_secondary_pin_oe;
  endproperty
  property p_act_level;
    ui == 3'h0 && !o_filter_input_misc_config[1] |-> o_primary_pin_out == !o_activation;
  endproperty
  property p_gated;
    s_gated_idle |-> o_secondary_pin_out;
  endproperty
  property p_soft;
    s_halt_end |-> ##[0:2] o_soft_reset;
  endproperty
  property p_pulse;
    (o_reseed || o_soft_reset) && i_clk_en |=> !o_reseed && !o_soft_reset;
  endproperty
  a_scan: assert property (p_scan) else $error("scan time wrong");
  a_shift: assert property (p_shift) else $error("filter shift wrong");
  a_freeze: assert property (p_freeze) else $error("freeze wrong");
  a_act_off: assert property (p_act_off) else $error("activation not released");
  a_prox_ui: assert property (p_prox_ui) else $error("prox pins wrong");
  a_input_ui: assert property (p_input_ui) else $error("input mode pins wrong");
  a_act_level: assert property (p_act_level) else $error("primary level wrong");
  a_gated: assert property (p_gated) else $error("gated output active");
  a_soft: assert property (p_soft) else $error("no soft reset");
  a_pulse: assert property (p_pulse) else $error("pulse too long");
endmodule : pmoc_top_sva
`default_nettype wire

// ---- dv/pmoc_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module pmoc_bench;
  localparam int MS = 4;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic wr = 1'b0, sv = 1'b0, hstart = 1'b0, pin2;
  logic en = 1'b1;
  logic [7:0] sc = 8'h00, th = 8'h00, tm = 8'h00, mi = 8'h00, hms = 8'h00;
  logic [11:0] long_term_average = 12'h000, ld = 12'h000, md = 12'h000;
  logic p1, p1oe, p2, p2oe, act, frz, rsd, halt, srst, red;
  logic [2:0] shift;
  logic [7:0] scan_ms, rb0, rb1, rb2, rb3;
  int bad_count = 0, check_count = 0, cyc = 0, rs_cnt = 0, sr_cnt = 0, n = 0;
  int pct[8] = '{2, 4, 6, 10, 15, 30, 60, 90};

  pmoc_host #(.MS_CYCLES(MS)) u_host (.i_clock(i_clock), .i_start(hstart), .i_low_ms(hms),
    .o_pin(pin2));
  pmoc_top #(.MS_CYCLES(MS)) dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_clk_en(en),
    .i_cfg_write(wr), .i_scan_time_config(sc), .i_threshold_config(th),
    .i_timer_output_ui_config(tm), .i_filter_input_misc_config(mi), .i_sample_valid(sv),
    .i_lta(long_term_average), .i_lta_delta(ld), .i_move_delta(md), .i_primary_pin_in(1'b1),
    .i_secondary_pin_in(pin2), .o_primary_pin_out(p1), .o_primary_pin_oe(p1oe),
    .o_secondary_pin_out(p2), .o_secondary_pin_oe(p2oe), .o_activation(act),
    .o_filter_freeze(frz), .o_reseed(rsd), .o_halt_charge(halt), .o_soft_reset(srst),
    .o_reduced(red), .o_ac_filter_shift(shift), .o_act_scan_ms(scan_ms),
    .o_scan_time_config(rb0), .o_threshold_config(rb1), .o_timer_output_ui_config(rb2),
    .o_filter_input_misc_config(rb3));

  always #4 i_clock = ~i_clock;

  // ----------------------------------------
  // Pulse counters and hang guard
  // ----------------------------------------
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    rs_cnt <= rs_cnt + int'(rsd === 1'b1);
    sr_cnt <= sr_cnt + int'(srst === 1'b1);
    if (cyc == 40000) begin
      $display("ERROR %0t run did not finish in time", $time);
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic cfg(input logic [7:0] a, b, c, d);
    @(posedge i_clock);
    sc <= a;
    th <= b;
    tm <= c;
    mi <= d;
    wr <= 1'b1;
    @(posedge i_clock);
    wr <= 1'b0;
    @(negedge i_clock);
  endtask : cfg

  task automatic smp(input logic [11:0] l, d, m);
    @(posedge i_clock);
    sv <= 1'b1;
    long_term_average <= l;
    ld <= d;
    md <= m;
    @(posedge i_clock);
    sv <= 1'b0;
    @(negedge i_clock);
  endtask : smp

  task automatic pulse(input logic [7:0] ms, input int w);
    @(posedge i_clock);
    hstart <= 1'b1;
    hms <= ms;
    @(posedge i_clock);
    hstart <= 1'b0;
    repeat (w * MS) @(posedge i_clock);
    @(negedge i_clock);
  endtask : pulse

  // Counts low cycles of the movement pin over a 200 ms window after a settling time.
  task automatic pulse_density_output(input logic [7:0] t, m, input logic [11:0] d, mv);
    cfg(8'h00, 8'h00, t, m);
    smp(12'h064, d, mv);
    repeat (25 * MS) @(posedge i_clock);
    n = 0;
    repeat (200 * MS) begin
      @(negedge i_clock);
      n += int'(p2 === 1'b0);
    end
  endtask : pulse_density_output

  initial begin
    repeat (3) @(posedge i_clock);
    i_arst_n <= 1'b1;
    repeat (6) @(posedge i_clock);
    cfg(8'h03, 8'h21, 8'h00, 8'h04);
    chk(rb0, 8'h03);
    chk(rb1, 8'h21);
    chk(rb3, 8'h04);
    for (int c = 0; c < 8; c++) begin
      cfg(8'(c & 3), 8'(c << 2), 8'h00, 8'h00);
      smp(12'h064, 12'(pct[c] + 1), 12'h000);
      chk(act, 1'h1);
      chk(p1, 1'h0);
      chk(scan_ms, 12'(16 << (c & 3)));
      smp(12'h064, 12'(pct[c]), 12'h000);
      chk(act, 1'h0);
    end
    // A sample offered while the clock enable is low must leave the state untouched.
    @(posedge i_clock);
    en <= 1'b0;
    smp(12'h064, 12'h064, 12'h000);
    chk(act, 1'h0);
    @(posedge i_clock);
    en <= 1'b1;
    cfg(8'h00, 8'h8C, 8'h00, 8'h00);
    smp(12'h064, 12'h00B, 12'h000);
    smp(12'h064, 12'h006, 12'h000);
    chk(act, 1'h1);
    smp(12'h064, 12'h004, 12'h000);
    chk(act, 1'h0);
    for (int c = 0; c < 4; c++) begin
      cfg(8'h00, 8'(c << 5), 8'h03, 8'h00);
      smp(12'h064, 12'((2 << c) + 1), 12'h000);
      chk(frz, 1'h1);
      chk(p1, 1'h0);
      chk(p2, 1'h0);
      smp(12'h064, 12'(2 << c), 12'h000);
      chk(p1, 1'h1);
    end
    cfg(8'h00, 8'h00, 8'h02, 8'h02);
    chk(shift, 3'h2);
    chk(rb2, 8'h02);
    chk(p2oe, 1'h0);
    pulse(8'h14, 24);
    chk(red, 1'h1);
    chk(shift, 3'h3);
    chk(12'(rs_cnt), 12'h0);
    smp(12'h064, 12'h00C, 12'h000);
    chk(act, 1'h0);
    smp(12'h064, 12'h00D, 12'h000);
    chk(act, 1'h1);
    cfg(8'h00, 8'h00, 8'h02, 8'h06);
    chk(shift, 3'h4);
    cfg(8'h00, 8'h00, 8'h02, 8'h00);
    pulse(8'h14, 24);
    chk(12'(rs_cnt), 12'h1);
    pulse(8'h0A, 14);
    chk(12'(rs_cnt), 12'h1);
    pulse(8'h46, 60);
    chk(halt, 1'h1);
    repeat (14 * MS) @(posedge i_clock);
    @(negedge i_clock);
    chk(halt, 1'h0);
    chk(12'(sr_cnt), 12'h1);
    chk(act, 1'h1);
    pulse_density_output(8'h00, 8'h00, 12'h000, 12'h0FB);
    chk(12'(n >= 360 && n <= 440), 12'h1);
    pulse_density_output(8'h00, 8'h00, 12'h000, 12'h0FC);
    chk(12'(n), 12'h320);
    pulse_density_output(8'h08, 8'h00, 12'h000, 12'h0FC);
    chk(12'(n), 12'h320);
    pulse_density_output(8'h08, 8'h02, 12'h000, 12'h0FB);
    chk(12'(n >= 360 && n <= 440), 12'h1);
    pulse_density_output(8'h18, 8'h00, 12'h000, 12'h0FB);
    chk(12'(n), 12'h000);
    pulse_density_output(8'h18, 8'h00, 12'h032, 12'h0FB);
    chk(12'(n >= 360 && n <= 440), 12'h1);
    cfg(8'h00, 8'h00, 8'h10, 8'h00);
    smp(12'h064, 12'h032, 12'h00A);
    chk(p2, 1'h0);
    repeat (19800) @(posedge i_clock);
    @(negedge i_clock);
    chk(act, 1'h1);
    chk(p2, 1'h0);
    repeat (400) @(posedge i_clock);
    @(negedge i_clock);
    chk(act, 1'h0);
    chk(p2, 1'h1);
    chk(12'(rs_cnt), 12'h2);
    print_verdict();
  end
endmodule : pmoc_bench

bind pmoc_top pmoc_top_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (.i_clock, .i_arst_n, .i_clk_en,
  .i_sample_valid, .i_lta, .i_lta_delta, .o_primary_pin_out, .o_primary_pin_oe,
  .o_secondary_pin_out, .o_secondary_pin_oe, .o_activation, .o_filter_freeze, .o_reseed,
  .o_halt_charge, .o_soft_reset, .o_reduced, .o_ac_filter_shift, .o_act_scan_ms,
  .o_scan_time_config, .o_threshold_config, .o_timer_output_ui_config,
  .o_filter_input_misc_config);
`default_nettype wire
